// ---- mps_sequencer.sv ----
// Notes on behaviour
// - The mirror supply enable rises within 150 us of the later of reset-in rising and supply-good rising.
// - The supply-good drive goes high on its own as soon as the block leaves reset.
// - The active-low mirror output-enable falls within 5 ms of the supply enable rising.
// - On a requested power-down, a preconditioning step of at least 800 us runs before the mirrors are parked.
// - Preconditioning ends by dropping the supply-good drive, which pulls supply-good low.
// - About 200 us is allowed for the mirrors to park before mirror power is removed.
// - The mirror supply enable falls within 500 us of the supply-good input going low.
`timescale 1ns/1ps
`default_nettype none

module mps_sequencer #(
    parameter int unsigned OE_MAX_CYC  = mps_pkg::OE_MAX_CYC,
    parameter int unsigned PRECOND_CYC = mps_pkg::PRECOND_MIN_CYC,
    parameter int unsigned PARK_CYC    = mps_pkg::PARK_CYC,
    parameter int unsigned PD_MAX_CYC  = mps_pkg::PD_MAX_CYC
) (
    input  wire logic CLOCK_I,
    input  wire logic RST_I,
    input  wire logic RESET_IN_N_I,         // system reset, low holds mirrors off
    input  wire logic SUPPLY_OK_INPUT_I,    // supply-good, looped back from the drive
    input  wire logic SHUTDOWN_REQ_I,       // level, high asks for power-down
    output logic      SUPPLY_OK_DRIVE_O,    // pin shared with red_led_pulse_out
    output logic      MIRROR_PWR_EN_O,
    output logic      MIRROR_OE_N_O,
    output logic      MIRRORS_OFF_O         // high once power-down has completed
);

    mps_pkg::mps_state_e state_ff;
    mps_pkg::mps_state_e nxt_state;
    logic                tmr_load;
    mps_pkg::mps_cnt_t   tmr_val;
    logic                tmr_done;
    logic                drive_ff;
    logic                pwr_en_ff;
    logic                oe_n_ff;
    logic                off_ff;
    logic                down_req;

    // power-down is asked for by the request line or by the system reset
    assign down_req = SHUTDOWN_REQ_I || !RESET_IN_N_I;

    // one shared timer serves every interval, since they never overlap
    mps_interval_timer u_timer (
        .clk_i      (CLOCK_I),
        .rst_i      (RST_I),
        .load_i     (tmr_load),
        .load_val_i (tmr_val),
        .done_o     (tmr_done)
    );

    // sequence decode; a supply-good loss while active skips straight to park
    always_comb begin
        nxt_state = state_ff;
        tmr_load  = 1'b0;
        tmr_val   = mps_pkg::CNT_ZERO;
        unique case (state_ff)
            mps_pkg::ST_HOLD: begin
                nxt_state = mps_pkg::ST_WAIT_GOOD;
            end
            mps_pkg::ST_WAIT_GOOD: begin
                if (RESET_IN_N_I && SUPPLY_OK_INPUT_I && !SHUTDOWN_REQ_I) begin
                    nxt_state = mps_pkg::ST_SETTLE;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(mps_pkg::OE_SETTLE_CYC);
                end
            end
            mps_pkg::ST_SETTLE: begin
                if (!SUPPLY_OK_INPUT_I) begin
                    nxt_state = mps_pkg::ST_PARK;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(PARK_CYC);
                end else if (tmr_done) begin
                    nxt_state = mps_pkg::ST_RUN;
                end
            end
            mps_pkg::ST_RUN: begin
                if (!SUPPLY_OK_INPUT_I) begin
                    nxt_state = mps_pkg::ST_PARK;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(PARK_CYC);
                end else if (down_req) begin
                    nxt_state = mps_pkg::ST_PRECOND;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(PRECOND_CYC);
                end
            end
            mps_pkg::ST_PRECOND: begin
                if (!SUPPLY_OK_INPUT_I) begin
                    nxt_state = mps_pkg::ST_PARK;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(PARK_CYC);
                end else if (tmr_done) begin
                    nxt_state = mps_pkg::ST_WAIT_LOW;
                end
            end
            mps_pkg::ST_WAIT_LOW: begin
                // relies on the loop-back to bring the input down
                if (!SUPPLY_OK_INPUT_I) begin
                    nxt_state = mps_pkg::ST_PARK;
                    tmr_load  = 1'b1;
                    tmr_val   = mps_pkg::mps_cnt_t'(PARK_CYC);
                end
            end
            mps_pkg::ST_PARK: begin
                if (tmr_done) begin
                    nxt_state = mps_pkg::ST_OFF;
                end
            end
            mps_pkg::ST_OFF: begin
                if (!down_req) begin
                    nxt_state = mps_pkg::ST_WAIT_GOOD;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_ff <= mps_pkg::ST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // supply-good drive: high from reset release until preconditioning ends or a supply-good loss sends the sequence to park
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            drive_ff <= 1'b0;
        end else begin
            drive_ff <= (nxt_state == mps_pkg::ST_WAIT_GOOD) ||
                        (nxt_state == mps_pkg::ST_SETTLE) ||
                        (nxt_state == mps_pkg::ST_RUN) ||
                        (nxt_state == mps_pkg::ST_PRECOND);
        end
    end

    // mirror supply enable, held on through park so the mirrors land powered
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            pwr_en_ff <= 1'b0;
        end else begin
            pwr_en_ff <= (nxt_state == mps_pkg::ST_SETTLE) ||
                         (nxt_state == mps_pkg::ST_RUN) ||
                         (nxt_state == mps_pkg::ST_PRECOND) ||
                         (nxt_state == mps_pkg::ST_WAIT_LOW) ||
                         (nxt_state == mps_pkg::ST_PARK);
        end
    end

    // output-enable low only while mirrors are meant to be active
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            oe_n_ff <= 1'b1;
        end else begin
            oe_n_ff <= !((nxt_state == mps_pkg::ST_RUN) ||
                         (nxt_state == mps_pkg::ST_PRECOND) ||
                         (nxt_state == mps_pkg::ST_WAIT_LOW));
        end
    end

    // completion flag for the system controller
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            off_ff <= 1'b0;
        end else begin
            off_ff <= (nxt_state == mps_pkg::ST_OFF);
        end
    end

    assign SUPPLY_OK_DRIVE_O = drive_ff;
    assign MIRROR_PWR_EN_O   = pwr_en_ff;
    assign MIRROR_OE_N_O     = oe_n_ff;
    assign MIRRORS_OFF_O     = off_ff;

    // helper counters watched only by the checks below
    mps_pkg::mps_cnt_t up_wait_ff;
    mps_pkg::mps_cnt_t oe_wait_ff;
    mps_pkg::mps_cnt_t pre_len_ff;
    mps_pkg::mps_cnt_t park_len_ff;
    mps_pkg::mps_cnt_t pd_wait_ff;

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            up_wait_ff  <= mps_pkg::CNT_ZERO;
            oe_wait_ff  <= mps_pkg::CNT_ZERO;
            pre_len_ff  <= mps_pkg::CNT_ZERO;
            park_len_ff <= mps_pkg::CNT_ZERO;
            pd_wait_ff  <= mps_pkg::CNT_ZERO;
        end else begin
            up_wait_ff  <= (RESET_IN_N_I && SUPPLY_OK_INPUT_I && !pwr_en_ff &&
                            state_ff == mps_pkg::ST_WAIT_GOOD && !SHUTDOWN_REQ_I) ?
                           up_wait_ff + mps_pkg::CNT_ONE : mps_pkg::CNT_ZERO;
            oe_wait_ff  <= (pwr_en_ff && oe_n_ff && state_ff == mps_pkg::ST_SETTLE) ?
                           oe_wait_ff + mps_pkg::CNT_ONE : mps_pkg::CNT_ZERO;
            pre_len_ff  <= (state_ff == mps_pkg::ST_PRECOND) ?
                           pre_len_ff + mps_pkg::CNT_ONE : mps_pkg::CNT_ZERO;
            park_len_ff <= (state_ff == mps_pkg::ST_PARK) ?
                           park_len_ff + mps_pkg::CNT_ONE : mps_pkg::CNT_ZERO;
            pd_wait_ff  <= (!SUPPLY_OK_INPUT_I && pwr_en_ff) ?
                           pd_wait_ff + mps_pkg::CNT_ONE : mps_pkg::CNT_ZERO;
        end
    end

    a_enable_rise_bound: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        up_wait_ff <= mps_pkg::mps_cnt_t'(mps_pkg::PWR_EN_MAX_CYC))
        else $error("supply enable late after reset and supply-good");

    a_drive_after_reset: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $fell(RST_I) |=> SUPPLY_OK_DRIVE_O)
        else $error("supply-good drive not raised after reset");

    a_oe_fall_bound: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        oe_wait_ff <= mps_pkg::mps_cnt_t'(OE_MAX_CYC))
        else $error("output-enable not low in time after enable");

    a_precond_min_len: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_ff == mps_pkg::ST_PRECOND && nxt_state == mps_pkg::ST_WAIT_LOW)
        |-> pre_len_ff >= mps_pkg::mps_cnt_t'(PRECOND_CYC))
        else $error("preconditioning too short");

    a_precond_drive_drop: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        (state_ff == mps_pkg::ST_PRECOND && nxt_state == mps_pkg::ST_WAIT_LOW)
        |=> !SUPPLY_OK_DRIVE_O && MIRROR_PWR_EN_O && $past(SUPPLY_OK_DRIVE_O))
        else $error("preconditioning did not end on drive drop");

    a_park_time_kept: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        $fell(MIRROR_PWR_EN_O) |-> park_len_ff >= mps_pkg::mps_cnt_t'(PARK_CYC))
        else $error("mirror power removed before park time");

    a_pd_enable_fall: assert property (
        @(posedge CLOCK_I) disable iff (RST_I)
        pd_wait_ff <= mps_pkg::mps_cnt_t'(PD_MAX_CYC))
        else $error("supply enable not dropped in time");

    a_reset_safe_out: assert property (
        @(posedge CLOCK_I)
        RST_I |=> MIRROR_OE_N_O && !MIRROR_PWR_EN_O)
        else $error("outputs not safe under reset");

endmodule : mps_sequencer

`default_nettype wire

// ---- mps_pkg.sv ----
package mps_pkg;

    // clock rate and unit conversion
    localparam int CLK_PERIOD_NS = 40;
    localparam int NS_PER_US     = 1000;
    localparam int NS_PER_MS     = 1000000;

    // interval figures in their own units
    localparam int T_PWR_EN_MAX_US   = 150;  // reset/supply-good rise to enable rise, max
    localparam int T_OE_MAX_MS       = 5;    // enable rise to output-enable fall, max
    localparam int T_OE_SETTLE_US    = 100;  // supply settle before mirrors go active
    localparam int T_PRECOND_MIN_US  = 800;  // preconditioning, min
    localparam int T_PARK_US         = 200;  // mirror park time
    localparam int T_PD_MAX_US       = 500;  // supply-good low to enable fall, max

    // least time: round up, never below one cycle
    function automatic int mps_cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : mps_cyc_min

    // longest time: round down, never below one cycle
    function automatic int mps_cyc_max(input int t_ns);
        int c;
        c = t_ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : mps_cyc_max

    localparam int PWR_EN_MAX_CYC  = mps_cyc_max(T_PWR_EN_MAX_US * NS_PER_US);
    localparam int OE_MAX_CYC      = mps_cyc_max(T_OE_MAX_MS * NS_PER_MS);
    localparam int OE_SETTLE_CYC   = mps_cyc_min(T_OE_SETTLE_US * NS_PER_US);
    localparam int PRECOND_MIN_CYC = mps_cyc_min(T_PRECOND_MIN_US * NS_PER_US);
    localparam int PARK_CYC        = mps_cyc_min(T_PARK_US * NS_PER_US);
    localparam int PD_MAX_CYC      = mps_cyc_max(T_PD_MAX_US * NS_PER_US);

    localparam int CNT_W = 24;
    typedef logic [CNT_W-1:0] mps_cnt_t;
    localparam mps_cnt_t CNT_ZERO = 24'h000000;
    localparam mps_cnt_t CNT_ONE  = 24'h000001;

    typedef enum logic [2:0] {
        ST_HOLD      = 3'h0,
        ST_WAIT_GOOD = 3'h1,
        ST_SETTLE    = 3'h2,
        ST_RUN       = 3'h3,
        ST_PRECOND   = 3'h4,
        ST_WAIT_LOW  = 3'h5,
        ST_PARK      = 3'h6,
        ST_OFF       = 3'h7
    } mps_state_e;

endpackage : mps_pkg

// ---- mps_interval_timer.sv ----
`timescale 1ns/1ps
`default_nettype none

module mps_interval_timer (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             load_i,
    input  wire mps_pkg::mps_cnt_t load_val_i,
    output logic                  done_o
);

    mps_pkg::mps_cnt_t cnt_ff;

    // down counter; done is a level while it rests at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= mps_pkg::CNT_ZERO;
        end else if (load_i) begin
            cnt_ff <= load_val_i;
        end else if (cnt_ff != mps_pkg::CNT_ZERO) begin
            cnt_ff <= cnt_ff - mps_pkg::CNT_ONE;
        end
    end

    assign done_o = (cnt_ff == mps_pkg::CNT_ZERO);

endmodule : mps_interval_timer

`default_nettype wire

// ---- mps_supply_loop.sv ----
`timescale 1ns/1ps
`default_nettype none

module mps_supply_loop (
    input  wire logic       clk_i,
    input  wire logic       drive_i,
    input  wire logic       drop_i,
    input  wire logic [7:0] lag_i,
    input  wire logic       pwr_en_i,
    output var  logic       supply_ok_o,
    output var  logic       rail_o
);
    logic [7:0] lag_cnt_ff;

    // the rail starts discharged, so the input reads low until the drive comes up
    initial begin
        supply_ok_o = 1'b0;
        lag_cnt_ff  = 8'h00;
        rail_o      = 1'b0;
    end

    // mirror rail follows the enable with no added delay beyond one clock
    always @(posedge clk_i) begin
        rail_o <= pwr_en_i;
    end

    // supply-good follows the drive after lag_i+1 cycles; drop_i forces a brown-out
    always @(posedge clk_i) begin
        if (drop_i) begin
            supply_ok_o <= 1'b0;
            lag_cnt_ff  <= 8'h00;
        end else if (drive_i === supply_ok_o) begin
            lag_cnt_ff <= 8'h00;
        end else if (lag_cnt_ff >= lag_i) begin
            supply_ok_o <= drive_i;
            lag_cnt_ff  <= 8'h00;
        end else begin
            lag_cnt_ff <= lag_cnt_ff + 8'h01;
        end
    end
endmodule : mps_supply_loop

`default_nettype wire

// ---- mps_sequencer_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module mps_sequencer_tb_top;
    localparam int PRE_CYC  = 20;
    localparam int PARK_CYC = 10;
    localparam int PD_CYC   = 20;
    localparam int CEILING  = 20000;  // four power cycles of about 2700 cycles each

    logic       clock_i      = 1'b0;
    logic       rst_i        = 1'b1;
    logic       reset_in_n   = 1'b0;
    logic       shutdown_req = 1'b0;
    logic       drop         = 1'b0;
    logic [7:0] lag          = 8'h01;
    logic       supply_ok;
    logic       drive;
    logic       pwr_en;
    logic       oe_n;
    logic       off;
    logic       rail;
    int         err_count    = 0;
    int         tests_run    = 0;
    int         cyc          = 0;
    int         seed         = 32'h608F;
    int         n;
    int         h;

    mps_sequencer #(.PRECOND_CYC(PRE_CYC), .PARK_CYC(PARK_CYC), .PD_MAX_CYC(PD_CYC)) DUT (
        .CLOCK_I          (clock_i),
        .RST_I            (rst_i),
        .RESET_IN_N_I     (reset_in_n),
        .SUPPLY_OK_INPUT_I(supply_ok),
        .SHUTDOWN_REQ_I   (shutdown_req),
        .SUPPLY_OK_DRIVE_O(drive),
        .MIRROR_PWR_EN_O  (pwr_en),
        .MIRROR_OE_N_O    (oe_n),
        .MIRRORS_OFF_O    (off)
    );

    mps_supply_loop partner (
        .clk_i      (clock_i),
        .drive_i    (drive),
        .drop_i     (drop),
        .lag_i      (lag),
        .pwr_en_i   (pwr_en),
        .supply_ok_o(supply_ok),
        .rail_o     (rail)
    );

    // 25 MHz block clock
    initial begin
        forever #20 clock_i = ~clock_i;
    end

    // hang guard: counts as a mismatch and closes the run
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == CEILING) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish;
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    function automatic logic pick(input int sel);
        case (sel)
            0:       return drive;
            1:       return pwr_en;
            2:       return oe_n;
            default: return supply_ok;
        endcase
    endfunction : pick

    // expected window test, kept apart from the design's own arithmetic
    function automatic logic in_range(input int v, input int lo, input int hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_range

    // counts falling edges until the chosen output reaches val, bounded by limit
    task automatic wait_for(input int sel, input logic val, input int limit, output int cnt);
        cnt = 0;
        while (pick(sel) !== val && cnt < limit) begin
            @(negedge clock_i);
            cnt++;
        end
    endtask : wait_for

    initial begin
        for (int k = 0; k < 4; k++) begin
            // each pass starts with a fresh reset, also mid-run
            @(negedge clock_i);
            rst_i      = 1'b1;
            reset_in_n = 1'b0;
            lag        = (k == 0) ? 8'h01 : 8'(($unsigned($random(seed)) % 40) + 1);
            h          = $unsigned($random(seed)) % 60;
            repeat (8) @(negedge clock_i);
            `CHK("pwr_en in reset", 1'b0, pwr_en)
            `CHK("oe_n in reset", 1'b1, oe_n)
            `CHK("drive in reset", 1'b0, drive)
            rst_i = 1'b0;
            @(negedge clock_i);
            `CHK("drive after reset", 1'b1, drive)
            // system reset rises before or after supply-good, at random
            repeat (h) @(negedge clock_i);
            `CHK("pwr_en early", 1'b0, pwr_en)
            reset_in_n = 1'b1;
            wait_for(3, 1'b1, 100, n);
            wait_for(1, 1'b1, mps_pkg::PWR_EN_MAX_CYC + 5, n);
            `CHK("pwr_en delay", 1'b1, in_range(n, 1, mps_pkg::PWR_EN_MAX_CYC))
            wait_for(2, 1'b0, mps_pkg::OE_MAX_CYC + 5, n);
            `CHK("rail up at oe_n fall", 1'b1, rail)
            `CHK("oe_n delay", 1'b1, (n == mps_pkg::OE_SETTLE_CYC + 1))
            `CHK("oe_n bound", 1'b1, (n <= mps_pkg::OE_MAX_CYC))
            repeat (1 + $unsigned($random(seed)) % 20) @(negedge clock_i);
            if (k == 3) begin
                // brown-out while running: mirrors must still come down in time
                drop = 1'b1;
                wait_for(3, 1'b0, 5, n);
                wait_for(1, 1'b0, PD_CYC + 5, n);
                `CHK("brownout pwr_en", 1'b1, (n <= PD_CYC))
                `CHK("brownout oe_n", 1'b1, oe_n)
                `CHK("brownout drive", 1'b0, drive)
            end else begin
                if ($random(seed) & 1) begin
                    shutdown_req = 1'b1;
                end else begin
                    reset_in_n = 1'b0;
                end
                wait_for(0, 1'b0, PRE_CYC + 50, n);
                `CHK("precondition length", 1'b1, in_range(n, PRE_CYC, PRE_CYC + 4))
                `CHK("pwr_en at drive drop", 1'b1, pwr_en)
                wait_for(3, 1'b0, 100, n);
                wait_for(1, 1'b0, PD_CYC + 5, n);
                `CHK("park time", 1'b1, (n >= PARK_CYC))
                `CHK("power-down bound", 1'b1, (n <= PD_CYC))
                `CHK("oe_n parked", 1'b1, oe_n)
                `CHK("mirrors off", 1'b1, off)
            end
            @(negedge clock_i);
            drop         = 1'b0;
            shutdown_req = 1'b0;
        end
        tally_and_finish();
    end
endmodule : mps_sequencer_tb_top

`default_nettype wire
